/* bench/tb.sv */
/*
  self-checking bench of the capture/compare unit: register port tasks,
  event-counted captures, one-shot output and interrupt status.
  assumes tccu_pkg is compiled first and the trigger model drives the pins.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic resetn;
  logic [tccu_pkg::ADDR_W-1:0] addr;
  logic [tccu_pkg::CNT_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [tccu_pkg::CNT_W-1:0] rdata;
  logic trg_a, trg_b, gate, pin, eia, eib, cbi, irq;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_ia = 0;
  int n_ib = 0;
  int n_cb = 0;
  logic [31:0] seed;
  logic [15:0] cnt, c, va, vb;
  int n, d, p, k, m;

  always #4 clk = ~clk;

  tccu_top uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trigger_input_a(trg_a), .trigger_input_b(trg_b),
    .gate_timer_flipflop(gate), .flipflop_output_pin(pin), .ext_irq_a(eia),
    .ext_irq_b(eib), .compare_b_irq(cbi), .irq(irq));
  tccu_trig_model ptn (.clk(clk), .trigger_input_a(trg_a), .trigger_input_b(trg_b),
    .gate_timer_flipflop(gate));

  // pulses are one cycle wide, so counting high cycles counts events
  always @(posedge clk) begin
    if (eia === 1'b1) n_ia++;
    if (eib === 1'b1) n_ib++;
    if (cbi === 1'b1) n_cb++;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] mode_w(input logic run, input logic [1:0] cap);
    return {11'h000, run, cap, tccu_pkg::CLK_TRIG_A};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic draw(input int span, output int v);
    seed = lfsr(seed);
    v = 1 + int'(seed[7:0]) % span;
  endtask
  // counter ticks expected over a span of clock edges for a prescaler select
  function automatic logic [15:0] ticks(input logic [1:0] sel, input int span);
    logic [7:0] mask;
    mask = (sel == tccu_pkg::CLK_PRE_2) ? tccu_pkg::PRE_MASK_2 :
           (sel == tccu_pkg::CLK_PRE_8) ? tccu_pkg::PRE_MASK_8 : tccu_pkg::PRE_MASK_32;
    return 16'(span / (int'(mask) + 1));
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_get(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] v;
    rd_get(a, v);
    check(what, v, exp);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    seed = 32'hdb63_a0b1;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(tccu_pkg::OFS_MODE, 16'h0000, "mode");
    rd_chk(tccu_pkg::OFS_FFCTRL, 16'h0030, "ffctrl");
    rd_chk(tccu_pkg::OFS_CMP_B, 16'hffff, "cmp_b");
    wr_reg(tccu_pkg::OFS_CAP_A, 16'h1234);
    rd_chk(tccu_pkg::OFS_CAP_A, 16'h0000, "cap_a ro");
    draw(60000, n);
    draw(6, k);
    wr_reg(4'(9 + k), 16'(n));
    rd_chk(4'(9 + k), 16'h0000, "unmapped");
    wr_reg(tccu_pkg::OFS_CMP_A, 16'(n));
    rd_chk(tccu_pkg::OFS_CMP_A, 16'(n), "cmp_a rw");
    $display("test registers done");

    wr_reg(tccu_pkg::OFS_MODE, mode_w(1'b1, tccu_pkg::CAP_OFF));
    draw(8, n);
    for (int i = 0; i < n; i++) ptn.pulse_a(1);
    wr_reg(tccu_pkg::OFS_MODE, 16'h0000);
    cnt = 16'(n);
    rd_chk(tccu_pkg::OFS_COUNT, cnt, "event count");
    rd_chk(tccu_pkg::OFS_CAP_A, 16'h0000, "no capture");
    check("irq a count", 16'(n_ia), 16'(n));
    $display("test event count done");

    wr_reg(tccu_pkg::OFS_MODE, mode_w(1'b0, tccu_pkg::CAP_RISE_AB));
    ptn.pulse_a(2);
    ptn.pulse_b();
    rd_chk(tccu_pkg::OFS_CAP_A, cnt, "cap_a");
    rd_chk(tccu_pkg::OFS_CAP_A, cnt, "cap_a again");
    rd_chk(tccu_pkg::OFS_CAP_B, cnt, "cap_b");
    check("irq a count", 16'(n_ia), 16'(n + 1));
    check("irq b count", 16'(n_ib), 16'h0001);
    rd_chk(tccu_pkg::OFS_IRQ_STAT, 16'h0003, "status");
    check("irq masked", {15'h0000, irq}, 16'h0000);
    wr_reg(tccu_pkg::OFS_IRQ_EN, 16'h0001);
    @(posedge clk);
    #1;
    check("irq on", {15'h0000, irq}, 16'h0001);
    wr_reg(tccu_pkg::OFS_IRQ_CLR, 16'h0001);
    rd_chk(tccu_pkg::OFS_IRQ_STAT, 16'h0002, "status clr");
    check("irq off", {15'h0000, irq}, 16'h0000);
    $display("test captures and interrupts done");

    // trigger a clocks the counter, so the fall capture is one count on
    n = n_ia;
    wr_reg(tccu_pkg::OFS_MODE, mode_w(1'b1, tccu_pkg::CAP_PULSE_A));
    ptn.set_a(1'b1);
    repeat (4) @(posedge clk);
    check("no irq a on rise", 16'(n_ia), 16'(n));
    ptn.set_a(1'b0);
    repeat (4) @(posedge clk);
    check("irq a on fall", 16'(n_ia), 16'(n + 1));
    rd_chk(tccu_pkg::OFS_CAP_A, cnt, "width cap_a");
    rd_chk(tccu_pkg::OFS_CAP_B, cnt + 16'h0001, "width cap_b");
    cnt = cnt + 16'h0001;
    $display("test pulse width done");

    wr_reg(tccu_pkg::OFS_MODE, mode_w(1'b1, tccu_pkg::CAP_GATE));
    ptn.set_g(1'b1);
    draw(8, k);
    n = n_ia;
    for (int i = 0; i < k; i++) ptn.pulse_a(1);
    ptn.set_g(1'b0);
    rd_chk(tccu_pkg::OFS_CAP_A, cnt, "gate cap_a");
    rd_chk(tccu_pkg::OFS_CAP_B, cnt + 16'(k), "gate cap_b");
    check("irq a rising", 16'(n_ia), 16'(n + k));
    cnt = cnt + 16'(k);
    $display("test frequency done");

    wr_reg(tccu_pkg::OFS_MODE, mode_w(1'b1, tccu_pkg::CAP_RISE_AB));
    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0020);
    ptn.pulse_a(1);
    c = cnt;
    draw(6, d);
    d = d + 1;
    draw(6, p);
    wr_reg(tccu_pkg::OFS_CMP_A, c + 16'(d));
    wr_reg(tccu_pkg::OFS_CMP_B, c + 16'(d + p));
    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0033);
    for (int i = 0; i < d - 1; i++) ptn.pulse_a(1);
    check("pin after delay", {15'h0000, pin}, 16'h0001);
    for (int i = 0; i < p; i++) ptn.pulse_a(1);
    check("pin after width", {15'h0000, pin}, 16'h0000);
    check("cmp b irq", 16'(n_cb), 16'h0001);
    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0030);
    ptn.pulse_a(1);
    check("pin stopped", {15'h0000, pin}, 16'h0000);
    $display("test one-shot done");

    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0034);
    ptn.pulse_a(1);
    check("pin cap inv", {15'h0000, pin}, 16'h0001);
    ptn.pulse_a(1);
    check("pin cap inv 2", {15'h0000, pin}, 16'h0000);
    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0010);
    rd_chk(tccu_pkg::OFS_FFCTRL, 16'h0030, "ffctrl cmd");
    check("pin set", {15'h0000, pin}, 16'h0001);
    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0000);
    @(posedge clk);
    #1;
    check("pin invert", {15'h0000, pin}, 16'h0000);
    wr_reg(tccu_pkg::OFS_FFCTRL, 16'h0038);
    ptn.pulse_b();
    check("pin cap b inv", {15'h0000, pin}, 16'h0001);
    $display("test flip-flop commands done");

    // spans are whole multiples of 32 edges, so every divider sees whole periods
    for (int s = 1; s < 4; s++) begin
      wr_reg(tccu_pkg::OFS_MODE, mode_w(1'b1, tccu_pkg::CAP_RISE_AB) | 16'(s));
      draw(4, m);
      ptn.pulse_a(1);
      repeat (32 * m - 5) @(posedge clk);
      ptn.pulse_b();
      rd_get(tccu_pkg::OFS_CAP_A, va);
      rd_get(tccu_pkg::OFS_CAP_B, vb);
      check("prescaled span", vb - va, ticks(2'(s), 32 * m));
    end
    $display("test prescaler done");
    conclude();
  end
endmodule

/* bench/tccu_trig_model.sv */
/*
  far-side model: trigger inputs a and b and the gate level of the 16-bit timer.
  assumes the bench calls its tasks from one process, aligned to clk.
*/
`timescale 1ns/1ps
module tccu_trig_model (
  input wire logic clk,
  output logic trigger_input_a,
  output logic trigger_input_b,
  output logic gate_timer_flipflop
);
  initial begin
    trigger_input_a = 1'b0;
    trigger_input_b = 1'b0;
    gate_timer_flipflop = 1'b0;
  end
  // --------------------------------------------------------------
  // level changes land just after a rising edge
  // --------------------------------------------------------------
  task automatic set_a(input logic v);
    @(posedge clk);
    trigger_input_a <= v;
  endtask
  task automatic set_b(input logic v);
    @(posedge clk);
    trigger_input_b <= v;
  endtask
  task automatic set_g(input logic v);
    @(posedge clk);
    gate_timer_flipflop <= v;
    repeat (3) @(posedge clk);
  endtask
  // settle time after release covers capture, flip-flop and pulse latency
  task automatic pulse_a(input int h);
    set_a(1'b1);
    repeat (h) @(posedge clk);
    trigger_input_a <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse_b();
    set_b(1'b1);
    @(posedge clk);
    trigger_input_b <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* logic/tccu_edge.sv */
/*
  rise and fall detector for a group of synchronous input levels.
  assumes the inputs already belong to the clk domain.
*/
`timescale 1ns/1ps
module tccu_edge #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= sig;
    end
  end

  assign rise = sig & ~prev_r;
  assign fall = ~sig & prev_r;

endmodule

/* logic/tccu_top.sv */
/*
  capture and compare section of a 16-bit up-counting timer, with its
  register port and interrupt status, enable and clear registers.
  assumes trigger and gate inputs synchronous to clk, and a master that
  never issues read and write strobes in the same cycle.
*/
`timescale 1ns/1ps
module tccu_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [tccu_pkg::ADDR_W-1:0] addr,
  input wire logic [tccu_pkg::CNT_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [tccu_pkg::CNT_W-1:0] rdata,
  input wire logic trigger_input_a,
  input wire logic trigger_input_b,
  input wire logic gate_timer_flipflop,
  output logic flipflop_output_pin,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic compare_b_irq,
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tccu_pkg::tccu_mode_t mode_r;
  tccu_pkg::tccu_ffctrl_t ffc_r;
  logic [tccu_pkg::CNT_W-1:0] cmp_a_r, cmp_b_r, cap_a_r, cap_b_r, cnt_r, cnt_nxt;
  logic [tccu_pkg::PRE_W-1:0] pre_r;
  logic [tccu_pkg::IRQ_W-1:0] stat_r, stat_nxt, en_r;
  logic [tccu_pkg::CNT_W-1:0] rdata_r, rd_mux;
  logic ff_r, ff_nxt, ext_a_r, ext_b_r, cmp_b_irq_r, irq_r;

  // ------------------------------------------------------------
  // input edges
  // ------------------------------------------------------------
  logic [2:0] rise, fall;
  logic a_rise, a_fall, b_rise, g_rise, g_fall;

  tccu_edge #(.W(3)) u_edge (
    .clk(clk),
    .resetn(resetn),
    .sig({gate_timer_flipflop, trigger_input_b, trigger_input_a}),
    .rise(rise),
    .fall(fall)
  );

  assign a_rise = rise[0];
  assign a_fall = fall[0];
  assign b_rise = rise[1];
  assign g_rise = rise[2];
  assign g_fall = fall[2];

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic wr_mode, wr_ffc, wr_cmp_a, wr_cmp_b, wr_en, wr_clr;

  assign wr_mode = wr && (addr == tccu_pkg::OFS_MODE);
  assign wr_ffc = wr && (addr == tccu_pkg::OFS_FFCTRL);
  assign wr_cmp_a = wr && (addr == tccu_pkg::OFS_CMP_A);
  assign wr_cmp_b = wr && (addr == tccu_pkg::OFS_CMP_B);
  assign wr_en = wr && (addr == tccu_pkg::OFS_IRQ_EN);
  assign wr_clr = wr && (addr == tccu_pkg::OFS_IRQ_CLR);

  // ------------------------------------------------------------
  // counter clock
  // ------------------------------------------------------------
  function automatic logic tccu_tap(input logic [tccu_pkg::PRE_W-1:0] pre,
                                    input logic [tccu_pkg::PRE_W-1:0] mask);
    tccu_tap = ((pre & mask) == mask);
  endfunction

  function automatic logic tccu_hit(input logic tick,
                                    input logic [tccu_pkg::CNT_W-1:0] nxt,
                                    input logic [tccu_pkg::CNT_W-1:0] cmp);
    tccu_hit = tick && (nxt == cmp);
  endfunction

  logic cnt_tick, pre_tick;

  assign pre_tick = (mode_r.clk_sel == tccu_pkg::CLK_PRE_2) ?
                      tccu_tap(pre_r, tccu_pkg::PRE_MASK_2) :
                    (mode_r.clk_sel == tccu_pkg::CLK_PRE_8) ?
                      tccu_tap(pre_r, tccu_pkg::PRE_MASK_8) :
                      tccu_tap(pre_r, tccu_pkg::PRE_MASK_32);
  // event counting counts trigger a rises; the prescaler taps otherwise
  assign cnt_tick = mode_r.run &&
                    ((mode_r.clk_sel == tccu_pkg::CLK_TRIG_A) ? a_rise : pre_tick);
  assign cnt_nxt = cnt_tick ? cnt_r + 16'h0001 : cnt_r;

  // ------------------------------------------------------------
  // capture and interrupt events
  // ------------------------------------------------------------
  logic cap_a_ld, cap_b_ld, ev_ext_a, hit_a, hit_b;

  assign cap_a_ld = ((mode_r.cap_mode == tccu_pkg::CAP_RISE_AB) && a_rise) ||
                    ((mode_r.cap_mode == tccu_pkg::CAP_PULSE_A) && a_rise) ||
                    ((mode_r.cap_mode == tccu_pkg::CAP_GATE) && g_rise);
  assign cap_b_ld = ((mode_r.cap_mode == tccu_pkg::CAP_RISE_AB) && b_rise) ||
                    ((mode_r.cap_mode == tccu_pkg::CAP_PULSE_A) && a_fall) ||
                    ((mode_r.cap_mode == tccu_pkg::CAP_GATE) && g_fall);
  // pulse width mode reports at the end of the pulse, when both captures are in
  assign ev_ext_a = (mode_r.cap_mode == tccu_pkg::CAP_PULSE_A) ? a_fall : a_rise;
  assign hit_a = tccu_hit(cnt_tick, cnt_nxt, cmp_a_r);
  assign hit_b = tccu_hit(cnt_tick, cnt_nxt, cmp_b_r);

  // ------------------------------------------------------------
  // output flip-flop
  // ------------------------------------------------------------
  logic tog, sw_cmd;
  logic [1:0] cmd;

  assign tog = (hit_a && ffc_r.inv_a) ^ (hit_b && ffc_r.inv_b) ^
               (cap_a_ld && ffc_r.cap_inv_a) ^ (cap_b_ld && ffc_r.cap_inv_b);
  assign cmd = wdata[5:4];
  assign sw_cmd = wr_ffc && (cmd != tccu_pkg::FF_NONE);
  // a software set or clear wins over a hardware inversion in the same cycle
  assign ff_nxt = !wr_ffc ? ff_r ^ tog :
                  (cmd == tccu_pkg::FF_SET) ? 1'b1 :
                  (cmd == tccu_pkg::FF_CLEAR) ? 1'b0 :
                  (cmd == tccu_pkg::FF_INVERT) ? ~ff_r ^ tog : ff_r ^ tog;

  // set wins over clear so an event in the clearing cycle survives
  assign stat_nxt = (stat_r & ~(wr_clr ? wdata[tccu_pkg::IRQ_W-1:0] : 4'h0)) |
                    {hit_b, hit_a, b_rise, ev_ext_a};

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  assign rd_mux = (addr == tccu_pkg::OFS_MODE) ? mode_r :
                  (addr == tccu_pkg::OFS_FFCTRL) ? ffc_r :
                  (addr == tccu_pkg::OFS_CMP_A) ? cmp_a_r :
                  (addr == tccu_pkg::OFS_CMP_B) ? cmp_b_r :
                  (addr == tccu_pkg::OFS_CAP_A) ? cap_a_r :
                  (addr == tccu_pkg::OFS_CAP_B) ? cap_b_r :
                  (addr == tccu_pkg::OFS_COUNT) ? cnt_r :
                  (addr == tccu_pkg::OFS_IRQ_STAT) ? {12'h000, stat_r} :
                  (addr == tccu_pkg::OFS_IRQ_EN) ? {12'h000, en_r} : 16'h0000;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= tccu_pkg::MODE_RST;
      ffc_r <= tccu_pkg::FFCTRL_RST;
      cmp_a_r <= tccu_pkg::CMP_RST;
      cmp_b_r <= tccu_pkg::CMP_RST;
      en_r <= 4'h0;
    end else begin
      if (wr_mode) begin
        mode_r <= {11'h000, wdata[4:0]};
      end
      // the command field is an action, so it always reads back as no-op
      if (wr_ffc) begin
        ffc_r <= {10'h000, tccu_pkg::FF_NONE, wdata[3:0]};
      end
      if (wr_cmp_a) begin
        cmp_a_r <= wdata;
      end
      if (wr_cmp_b) begin
        cmp_b_r <= wdata;
      end
      if (wr_en) begin
        en_r <= wdata[tccu_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_r <= 8'h00;
      cnt_r <= 16'h0000;
      cap_a_r <= 16'h0000;
      cap_b_r <= 16'h0000;
    end else begin
      pre_r <= mode_r.run ? pre_r + 8'h01 : 8'h00;
      cnt_r <= cnt_nxt;
      if (cap_a_ld) begin
        cap_a_r <= cnt_r;
      end
      if (cap_b_ld) begin
        cap_b_r <= cnt_r;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ff_r <= 1'b0;
      stat_r <= 4'h0;
      ext_a_r <= 1'b0;
      ext_b_r <= 1'b0;
      cmp_b_irq_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ff_r <= ff_nxt;
      stat_r <= stat_nxt;
      ext_a_r <= ev_ext_a;
      ext_b_r <= b_rise;
      cmp_b_irq_r <= hit_b;
      irq_r <= |(stat_nxt & (wr_en ? wdata[tccu_pkg::IRQ_W-1:0] : en_r));
      rdata_r <= rd ? rd_mux : 16'h0000;
    end
  end

  assign flipflop_output_pin = ff_r;
  assign ext_irq_a = ext_a_r;
  assign ext_irq_b = ext_b_r;
  assign compare_b_irq = cmp_b_irq_r;
  assign irq = irq_r;
  assign rdata = rdata_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic only_tog;
  assign only_tog = !wr_ffc && tog;

  property p_cap_a_rise;
    (mode_r.cap_mode == tccu_pkg::CAP_RISE_AB) && a_rise |=> cap_a_r == $past(cnt_r);
  endproperty
  a_cap_a_rise: assert property (p_cap_a_rise) else $error("capture a missed");

  property p_ext_a;
    (mode_r.cap_mode != tccu_pkg::CAP_PULSE_A) && a_rise |=> ext_irq_a ##1 !ext_irq_a;
  endproperty
  a_ext_a: assert property (p_ext_a) else $error("interrupt a not pulsed");

  property p_cap_b;
    (mode_r.cap_mode == tccu_pkg::CAP_RISE_AB) && b_rise |=>
      (cap_b_r == $past(cnt_r)) && ext_irq_b;
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("capture b or interrupt b missed");

  property p_gate;
    (mode_r.cap_mode == tccu_pkg::CAP_GATE) && g_fall |=> cap_b_r == $past(cnt_r);
  endproperty
  a_gate: assert property (p_gate) else $error("gate fall capture missed");

  property p_pulse;
    (mode_r.cap_mode == tccu_pkg::CAP_PULSE_A) && a_fall |=>
      (cap_b_r == $past(cnt_r)) && $stable(cap_a_r);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse fall capture wrong");

  property p_ext_a_pulse;
    (mode_r.cap_mode == tccu_pkg::CAP_PULSE_A) && a_rise |=> !ext_irq_a;
  endproperty
  a_ext_a_pulse: assert property (p_ext_a_pulse) else $error("interrupt a on rise");

  property p_match;
    ffc_r.inv_a && ffc_r.inv_b && hit_a && !hit_b && !(cap_a_ld && ffc_r.cap_inv_a) &&
      !(cap_b_ld && ffc_r.cap_inv_b) && !wr_ffc
      |=> flipflop_output_pin != $past(flipflop_output_pin);
  endproperty
  a_match: assert property (p_match) else $error("match did not invert");

  property p_cap_inv;
    ffc_r.cap_inv_a && cap_a_ld && only_tog && !hit_a && !hit_b && !cap_b_ld
      |=> flipflop_output_pin != $past(flipflop_output_pin);
  endproperty
  a_cap_inv: assert property (p_cap_inv) else $error("capture did not invert");

  property p_count;
    mode_r.run && (mode_r.clk_sel != tccu_pkg::CLK_TRIG_A) && !pre_tick |=> $stable(cnt_r);
  endproperty
  a_count: assert property (p_count) else $error("counter moved without tick");

  property p_hold;
    !cap_a_ld && !cap_b_ld |=> $stable(cap_a_r) && $stable(cap_b_r);
  endproperty
  a_hold: assert property (p_hold) else $error("capture changed without event");

  c_pulse_mode: cover property ((mode_r.cap_mode == tccu_pkg::CAP_PULSE_A) && a_fall);
  c_gate_mode: cover property ((mode_r.cap_mode == tccu_pkg::CAP_GATE) && g_rise);
  c_one_shot: cover property (hit_a && ffc_r.inv_a ##[1:1000] hit_b && ffc_r.inv_b);
  c_irq: cover property (irq);

endmodule

/* pkg/tccu_pkg.sv */
/*
  constants, register map and field layouts of the timer capture/compare unit.
  assumes one 125 MHz clock and a 16-bit plain register port with word indices.
*/
package tccu_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int PRE_W = 8;
  localparam int IRQ_W = 4;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FFCTRL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CAP_A = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CAP_B = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 4'h9;

  // ------------------------------------------------------------
  // field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] CLK_TRIG_A = 2'h0;
  localparam logic [1:0] CLK_PRE_2 = 2'h1;
  localparam logic [1:0] CLK_PRE_8 = 2'h2;
  localparam logic [1:0] CLK_PRE_32 = 2'h3;

  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_RISE_AB = 2'h1;
  localparam logic [1:0] CAP_PULSE_A = 2'h2;
  localparam logic [1:0] CAP_GATE = 2'h3;

  localparam logic [1:0] FF_INVERT = 2'h0;
  localparam logic [1:0] FF_SET = 2'h1;
  localparam logic [1:0] FF_CLEAR = 2'h2;
  localparam logic [1:0] FF_NONE = 2'h3;

  // prescaler tap masks: a tick when the masked bits are all ones
  localparam logic [PRE_W-1:0] PRE_MASK_2 = 8'h01;
  localparam logic [PRE_W-1:0] PRE_MASK_8 = 8'h07;
  localparam logic [PRE_W-1:0] PRE_MASK_32 = 8'h1f;

  // status bit positions
  localparam int IRQ_EXT_A = 0;
  localparam int IRQ_EXT_B = 1;
  localparam int IRQ_CMP_A = 2;
  localparam int IRQ_CMP_B = 3;

  // ------------------------------------------------------------
  // register layouts and reset values
  // ------------------------------------------------------------
  typedef struct packed {
    logic [10:0] rsvd;
    logic run;
    logic [1:0] cap_mode;
    logic [1:0] clk_sel;
  } tccu_mode_t;

  typedef struct packed {
    logic [9:0] rsvd;
    logic [1:0] ff_cmd;
    logic cap_inv_b;
    logic cap_inv_a;
    logic inv_b;
    logic inv_a;
  } tccu_ffctrl_t;

  localparam tccu_mode_t MODE_RST = 16'h0000;
  localparam tccu_ffctrl_t FFCTRL_RST = 16'h0030;
  localparam logic [CNT_W-1:0] CMP_RST = 16'hffff;

endpackage
